//--- rtl/power_mode_pkg.sv
package power_mode_pkg;

   localparam logic [4:0] REG_BASIC_CONTROL   = 5'h00;
   localparam logic [4:0] REG_FRONTEND_CTRL   = 5'h11;
   localparam logic [4:0] REG_EXPANDED_CTRL   = 5'h18;
   localparam logic [4:0] REG_PHY_CTRL_SECOND = 5'h1f;

   localparam int BIT_SOFT_RESET  = 15;
   localparam int BIT_ANEG_EN     = 12;
   localparam int BIT_POWER_DOWN  = 11;
   localparam int BIT_SLOW_OSC    = 5;
   localparam int BIT_EDPD_DIS_N  = 11;
   localparam int BIT_PSAVE_EN    = 10;

   localparam logic [15:0] BASIC_RESET    = 16'h1000;
   localparam logic [15:0] FRONTEND_RESET = 16'h0000;
   localparam logic [15:0] EXPANDED_RESET = 16'h0800;
   localparam logic [15:0] PHY2_RESET     = 16'h0000;
   localparam logic [15:0] BASIC_WMASK    = 16'hff80;

   localparam int CLOCK_MHZ          = 200;
   localparam int PULSE_NORMAL_US    = 16;
   localparam int PULSE_SLOW_FACTOR  = 8;
   localparam int PULSE_NORMAL_CYC   = PULSE_NORMAL_US * CLOCK_MHZ;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_PSAVE,
      MODE_EDPD,
      MODE_POWER_DOWN
   } power_mode_t;

   typedef struct packed {
      logic receiver_on;
      logic transmitter_on;
      logic energy_detect_on;
      logic pll_on;
      logic core_on;
      logic ref_clock_input_on;
      logic slow_osc_sel;
   } block_gates_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } mgmt_req_t;

endpackage

//--- rtl/phy_power_mode_control.sv
`timescale 1ns/1ps
module phy_power_mode_control
   import power_mode_pkg::*;
#(
   parameter int PULSE_SLOW_MULT = PULSE_SLOW_FACTOR
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire mgmt_req_t    req,
   output logic [15:0]       rdata,
   input  wire logic         link_up,
   output block_gates_t      gates,
   output power_mode_t       mode,
   output logic              link_pulse,
   output logic              chip_reset
);

   localparam int PULSE_SLOW_CYC = PULSE_NORMAL_CYC * PULSE_SLOW_MULT;
   localparam int CW = $clog2(PULSE_SLOW_CYC + 1);

   // a multiplier below one would make the stretched interval shorter
   if (PULSE_SLOW_MULT < 1) begin : g_bad_mult
      $error("slow pulse multiplier must be >= 1");
   end

   logic [15:0] basic_r, basic_nxt;
   logic [15:0] front_r, front_nxt;
   logic [15:0] exp_r, exp_nxt;
   logic [15:0] phy2_r, phy2_nxt;
   logic        reset_r, reset_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic        pulse_r, pulse_nxt;
   block_gates_t gates_r, gates_nxt;
   power_mode_t  mode_r, mode_nxt;
   logic [15:0]  rdata_r, rdata_nxt;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
      return a == r;
   endfunction

   // register file; the management interface stays alive in all modes
   always_comb begin
      basic_nxt = basic_r;
      front_nxt = front_r;
      exp_nxt   = exp_r;
      phy2_nxt  = phy2_r;
      reset_nxt = 1'b0;
      if (req.wr) begin
         if (hit(req.addr, REG_BASIC_CONTROL)) begin
            basic_nxt = req.wdata & BASIC_WMASK;
            basic_nxt[BIT_SOFT_RESET] = 1'b0;
            if (req.wdata[BIT_SOFT_RESET]) begin
               if (basic_r[BIT_POWER_DOWN]) begin
                  // first reset only leaves power-down
                  basic_nxt = basic_r;
                  basic_nxt[BIT_POWER_DOWN] = 1'b0;
               end else begin
                  reset_nxt = 1'b1;
               end
            end
         end else if (hit(req.addr, REG_FRONTEND_CTRL)) begin
            front_nxt = req.wdata;
         end else if (hit(req.addr, REG_EXPANDED_CTRL)) begin
            exp_nxt = req.wdata;
         end else if (hit(req.addr, REG_PHY_CTRL_SECOND)) begin
            phy2_nxt = req.wdata;
         end
      end
      if (reset_r) begin
         basic_nxt = BASIC_RESET;
         front_nxt = FRONTEND_RESET;
         exp_nxt   = EXPANDED_RESET;
         phy2_nxt  = PHY2_RESET;
      end
   end

   always_comb begin
      rdata_nxt = rdata_r;
      if (req.rd) begin
         if (hit(req.addr, REG_BASIC_CONTROL)) begin
            rdata_nxt = basic_r;
         end else if (hit(req.addr, REG_FRONTEND_CTRL)) begin
            rdata_nxt = front_r;
         end else if (hit(req.addr, REG_EXPANDED_CTRL)) begin
            rdata_nxt = exp_r;
         end else if (hit(req.addr, REG_PHY_CTRL_SECOND)) begin
            rdata_nxt = phy2_r;
         end else begin
            rdata_nxt = 16'h0000;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         basic_r <= BASIC_RESET;
         front_r <= FRONTEND_RESET;
         exp_r   <= EXPANDED_RESET;
         phy2_r  <= PHY2_RESET;
         reset_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else begin
         basic_r <= basic_nxt;
         front_r <= front_nxt;
         exp_r   <= exp_nxt;
         phy2_r  <= phy2_nxt;
         reset_r <= reset_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // mode selection; power-down wins over the link-idle modes
   logic idle_q;
   always_comb begin
      idle_q = basic_r[BIT_ANEG_EN] && !link_up;
      if (basic_r[BIT_POWER_DOWN]) begin
         mode_nxt = MODE_POWER_DOWN;
      end else if (idle_q && !exp_r[BIT_EDPD_DIS_N]) begin
         mode_nxt = MODE_EDPD;
      end else if (idle_q && phy2_r[BIT_PSAVE_EN]) begin
         mode_nxt = MODE_PSAVE;
      end else begin
         mode_nxt = MODE_NORMAL;
      end
   end

   always_comb begin
      gates_nxt = '{default: 1'b1};
      gates_nxt.slow_osc_sel = 1'b0;
      case (mode_nxt)
         MODE_PSAVE: begin
            gates_nxt.receiver_on = 1'b0;
         end
         MODE_EDPD: begin
            gates_nxt.receiver_on = 1'b0;
            gates_nxt.pll_on      = 1'b0;
         end
         MODE_POWER_DOWN: begin
            gates_nxt = '0;
         end
         default: begin
         end
      endcase
      if (front_r[BIT_SLOW_OSC]) begin
         // with power-down also set this is the lowest state
         gates_nxt.ref_clock_input_on = 1'b0;
         gates_nxt.slow_osc_sel       = 1'b1;
      end
   end

   // link pulse timer; interval stretched in energy-detect power-down
   always_comb begin
      cnt_nxt   = cnt_r + 1'b1;
      pulse_nxt = 1'b0;
      if (mode_r == MODE_POWER_DOWN) begin
         cnt_nxt = '0;
      end else if ((mode_r == MODE_EDPD) ?
                   (cnt_r >= CW'(PULSE_SLOW_CYC - 1)) :
                   (cnt_r >= CW'(PULSE_NORMAL_CYC - 1))) begin
         cnt_nxt   = '0;
         pulse_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_r  <= MODE_NORMAL;
         gates_r <= '{default: 1'b1, slow_osc_sel: 1'b0};
         cnt_r   <= '0;
         pulse_r <= 1'b0;
      end else begin
         mode_r  <= mode_nxt;
         gates_r <= gates_nxt;
         cnt_r   <= cnt_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   assign rdata      = rdata_r;
   assign gates      = gates_r;
   assign mode       = mode_r;
   assign link_pulse = pulse_r;
   assign chip_reset = reset_r;

endmodule // phy_power_mode_control

//--- sim/power_mode_checker.sv
`timescale 1ns/1ps
module power_mode_checker
   import power_mode_pkg::*;
#(
   parameter int PULSE_SLOW_MULT = 2
) (
   input wire logic         clock,
   input wire logic         rst_n,
   input wire mgmt_req_t    req,
   input wire logic [15:0]  rdata,
   input wire logic         link_up,
   input wire block_gates_t gates,
   input wire power_mode_t  mode,
   input wire logic         link_pulse,
   input wire logic         chip_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire bw = req.wr && req.addr == REG_BASIC_CONTROL;
   psave_gates_a: assert property (mode == MODE_PSAVE |->
      gates[6:3] == 4'h7) else $error("power saving gating wrong");
   edpd_gates_a: assert property (mode == MODE_EDPD |->
      gates[6:3] == 4'h6) else $error("energy detect gating wrong");
   pd_gates_a: assert property (mode == MODE_POWER_DOWN |->
      gates[6:1] == 6'h00) else $error("power-down gating wrong");
   osc_sel_a: assert property (gates.slow_osc_sel |->
      !gates.ref_clock_input_on) else $error("ref clock left on");
   link_qual_a: assert property (link_up |=>
      !(mode inside {MODE_PSAVE, MODE_EDPD})) else $error("low power w/ link");
   pd_enter_a: assert property (bw && req.wdata[11] && !req.wdata[15]
      |-> ##2 mode == MODE_POWER_DOWN) else $error("no power-down");
   pd_exit_a: assert property (mode == MODE_POWER_DOWN && bw &&
      !req.wdata[11] && !req.wdata[15] |-> ##2 mode != MODE_POWER_DOWN)
      else $error("power-down kept");
   sr_pd_a: assert property (mode == MODE_POWER_DOWN && bw &&
      req.wdata[15] |=> !chip_reset ##1 mode != MODE_POWER_DOWN)
      else $error("first soft reset in power-down wrong");
   pd_quiet_a: assert property (mode == MODE_POWER_DOWN &&
      $past(mode) == MODE_POWER_DOWN |-> !link_pulse) else $error("pulse in pd");
endmodule // power_mode_checker
bind phy_power_mode_control power_mode_checker
   #(.PULSE_SLOW_MULT(PULSE_SLOW_MULT)) chk_i (.clock(clock), .rst_n(rst_n),
   .req(req), .rdata(rdata), .link_up(link_up), .gates(gates), .mode(mode),
   .link_pulse(link_pulse), .chip_reset(chip_reset));

//--- sim/mgmt_ctrl.sv
`timescale 1ns/1ps
module mgmt_ctrl
   import power_mode_pkg::*;
(
   input  wire logic        clock,
   input  wire logic [15:0] rdata,
   output mgmt_req_t        req
);
   initial req = '0;
   // strobes are one-cycle pulses, so the request drops after its edge
   task automatic xfer(input logic w, input logic [4:0] a,
                       input logic [15:0] d, output logic [15:0] q);
      @(posedge clock);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clock);
      req <= '0;
      #1 q = rdata;
   endtask
endmodule // mgmt_ctrl

//--- sim/phy_power_mode_control_test.sv
`timescale 1ns/1ps
module phy_power_mode_control_test;
   import power_mode_pkg::*;
   logic         clock, rst_n, link_up, link_pulse, chip_reset;
   logic [15:0]  rdata, q;
   mgmt_req_t    req;
   block_gates_t gates;
   power_mode_t  mode;
   int           bad_count, num_checks, n;
   phy_power_mode_control #(.PULSE_SLOW_MULT(2)) uut (.clock(clock),
      .rst_n(rst_n), .req(req), .rdata(rdata), .link_up(link_up),
      .gates(gates), .mode(mode), .link_pulse(link_pulse),
      .chip_reset(chip_reset));
   mgmt_ctrl m (.clock(clock), .rdata(rdata), .req(req));
   initial begin
      clock = 0;
      forever #2.5 clock = ~clock;
   end
   task automatic chk(input string s, input logic [15:0] v, e);
      num_checks++;
      if (v !== e) begin
         bad_count++;
         $display("BAD %s exp %h saw %h", s, e, v);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      m.xfer(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [4:0] a, input logic [15:0] e);
      m.xfer(1'b0, a, 16'h0000, q);
      chk("rdata", q, e);
   endtask
   task automatic sm(input power_mode_t e, input logic [6:0] g);
      repeat (2) @(posedge clock);
      #1 chk("mode", 16'(mode), 16'(e));
      chk("gates", 16'(gates), 16'(g));
   endtask
   // measured from one pulse to the next, so a stale period is skipped
   task automatic gap(input int e);
      do @(negedge clock); while (link_pulse !== 1'b1);
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (link_pulse !== 1'b1);
      chk("gap", 16'(n), 16'(e));
   endtask
   task automatic finish_test;
      $display("checks %0d bad %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clock);
      bad_count++;
      finish_test();
   end
   initial begin
      rst_n = 0;
      link_up = 1;
      repeat (12) @(posedge clock);
      rst_n <= 1;
      rc(REG_BASIC_CONTROL, 16'h1000);
      rc(REG_FRONTEND_CTRL, 16'h0000);
      rc(REG_EXPANDED_CTRL, 16'h0800);
      rc(REG_PHY_CTRL_SECOND, 16'h0000);
      rc(5'h01, 16'h0000);
      wr(REG_BASIC_CONTROL, 16'h107f);
      rc(REG_BASIC_CONTROL, 16'h1000);
      wr(REG_PHY_CTRL_SECOND, 16'h0400);
      sm(MODE_NORMAL, 7'h7e);
      @(posedge clock) link_up <= 0;
      sm(MODE_PSAVE, 7'h3e);
      wr(REG_BASIC_CONTROL, 16'h0000);
      sm(MODE_NORMAL, 7'h7e);
      wr(REG_BASIC_CONTROL, 16'h1000);
      wr(REG_EXPANDED_CTRL, 16'h0000);
      sm(MODE_EDPD, 7'h36);
      gap(PULSE_NORMAL_CYC * 2);
      wr(REG_EXPANDED_CTRL, 16'h0800);
      sm(MODE_PSAVE, 7'h3e);
      gap(PULSE_NORMAL_CYC);
      wr(REG_FRONTEND_CTRL, 16'h0020);
      sm(MODE_PSAVE, 7'h3d);
      wr(REG_BASIC_CONTROL, 16'h1800);
      sm(MODE_POWER_DOWN, 7'h01);
      rc(REG_BASIC_CONTROL, 16'h1800);
      wr(REG_FRONTEND_CTRL, 16'h0000);
      wr(REG_BASIC_CONTROL, 16'h1000);
      sm(MODE_PSAVE, 7'h3e);
      wr(REG_BASIC_CONTROL, 16'h9000);
      chk("chip_reset", 16'(chip_reset), 16'h0001);
      rc(REG_PHY_CTRL_SECOND, 16'h0000);
      wr(REG_BASIC_CONTROL, 16'h1800);
      sm(MODE_POWER_DOWN, 7'h00);
      wr(REG_BASIC_CONTROL, 16'h8000);
      chk("chip_reset", 16'(chip_reset), 16'h0000);
      sm(MODE_NORMAL, 7'h7e);
      rc(REG_BASIC_CONTROL, 16'h1000);
      wr(REG_BASIC_CONTROL, 16'h8000);
      chk("chip_reset", 16'(chip_reset), 16'h0001);
      finish_test();
   end
endmodule // phy_power_mode_control_test
